/* rbs_pkg.sv */
// package for the reset and brownout sequencer: constants, states, carriers
package rbs_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS      = 50;
  // fixed clock count that reset waits after the oscillator runs
  localparam int unsigned RST_FIXED_CYCLES   = 64;
  // flash start-up time after power-down, in microseconds
  localparam int unsigned FLASH_WAKE_US      = 100;
  localparam int unsigned FLASH_WAKE_CYCLES  =
    (FLASH_WAKE_US * (CLK_HZ / 1_000_000) > 0) ? FLASH_WAKE_US * (CLK_HZ / 1_000_000) : 1;
  // deep-sleep resume counts for the two oscillator choices
  localparam int unsigned RESUME_RC_CYCLES   = 4;
  localparam int unsigned RESUME_MAIN_CYCLES = 4096;
  // hysteresis filter: a threshold input must hold this long to change state
  localparam int unsigned HYST_CYCLES        = 8;
  // processor start address after reset
  localparam logic [31:0] BOOT_ADDR          = 32'h0000_0000;
  localparam int unsigned CNT_W              = 13;

  // reset values of the status outputs
  localparam logic BROWNOUT_FLAG_RST = 1'b0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RBS_HOLD,       // a source holds reset
    RBS_WAIT_OSC,   // waiting for the oscillator
    RBS_COUNT,      // fixed clock count
    RBS_FLASH,      // flash controller initialising
    RBS_RUN,        // core running
    RBS_PD,         // power-down
    RBS_WAKE        // waking: flash timer and resume count
  } rbs_state_type;

  // raw reset sources, all active high
  typedef struct packed {
    logic ext_pin;    // external reset pin held low
    logic watchdog;
    logic por;
    logic brownout;   // second brownout stage (filtered)
  } rbs_src_type;

  // level comparator results from the analogue brownout_detector
  typedef struct packed {
    logic below_stage1;  // supply under the interrupt level
    logic below_stage2;  // supply under the reset level
  } rbs_cmp_type;

endpackage

/* rbs_hyst.sv */
// filter that adds hysteresis to one brownout comparator level
`timescale 1ns/1ps
`default_nettype none
module rbs_hyst
  import rbs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // comparator in, filtered level out
  input  wire logic raw_in,
  output logic      level_q
);
  logic [3:0] cnt_q, cnt_d;
  logic       level_d;

  // ----------------------------------------------------------------------
  // next state: the level only flips after HYST_CYCLES steady samples,
  // so a supply hovering on the threshold cannot chatter the output
  // ----------------------------------------------------------------------
  always_comb begin
    level_d = level_q;
    cnt_d   = 4'h0;
    if (raw_in != level_q) begin
      if (cnt_q == 4'(HYST_CYCLES - 1)) begin
        level_d = raw_in;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= BROWNOUT_FLAG_RST;
      cnt_q   <= 4'h0;
    end else begin
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end
endmodule
`default_nettype wire

/* rbs_seq.sv */
// reset and brownout sequencer top level
// How it works
// - four sources (pin, watchdog, power-on, brownout stage two) merge into chip reset.
// - any source asserting drives reset_out_pin low and restarts the wake-up timer.
// - reset holds until pin released, oscillator runs, count done, flash ready.
// - reset_out_pin rises on release; after brownout, only once supply recovers.
// - on release, the core fetch address is zero, the boot vector location.
// - downstream registers see reset active until release, so all hold reset values.
// - supply under 2.2 V raises the brownout interrupt request level.
// - the same first-stage level is presented as a readable status bit.
// - supply under 1.85 V forces chip reset, protecting flash.
// - brownout reset holds to about 1 V; power-on reset then holds it.
// - both brownout levels pass through a hysteresis filter.
// - an enabled external interrupt wakes the core from power-down.
// - after power-down, a flash timer counts clocks before flash access.
// - deep-sleep resume waits 4 rc cycles, or 4096 on main oscillator.
`timescale 1ns/1ps
`default_nettype none
module rbs_seq
  import rbs_pkg::*;
(
  // clock (internal_rc_oscillator) and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // reset sources
  input  wire logic        ext_rst_n,
  input  wire logic        wdt_rst,
  input  wire logic        por_rst,
  // brownout_detector comparator levels
  input  wire rbs_cmp_type brownout_cmp,
  // clocking and flash status
  input  wire logic        osc_running,
  input  wire logic        flash_init_done,
  input  wire logic        main_osc_sel,
  // power mode control from the core
  input  wire logic        pd_req,
  input  wire logic        deep_sleep_req,
  input  wire logic        ext_irq,
  input  wire logic        ext_irq_wake_en,
  // outputs
  output logic             reset_out_pin_n,
  output logic             chip_rst,
  output logic             brownout_irq,
  output logic             brownout_status,
  output logic [31:0]      fetch_addr,
  output logic             core_run,
  output logic             flash_access_ok
);
  rbs_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             from_brownout_q, from_brownout_d;
  logic             out_n_q, out_n_d;
  logic             flash_ok_q, flash_ok_d;
  logic             ds_q, ds_d;
  logic [1:0]       stage_lvl;   // [1] stage one, [0] stage two, as in the struct
  logic             stage1_lvl;
  logic             stage2_lvl;
  rbs_src_type      src;
  logic             any_src;

  // ----------------------------------------------------------------------
  // brownout filtering: one hysteresis filter per comparator level
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_hyst
    rbs_hyst rbs_hyst_inst (
      .clk     (clk),
      .rst     (rst),
      .raw_in  (brownout_cmp[i]),
      .level_q (stage_lvl[i])
    );
  end
  assign stage1_lvl = stage_lvl[1];
  assign stage2_lvl = stage_lvl[0];

  // ----------------------------------------------------------------------
  // source merge; por covers the range where brownout gives out
  // ----------------------------------------------------------------------
  always_comb begin
    src.ext_pin  = ~ext_rst_n;
    src.watchdog = wdt_rst;
    src.por      = por_rst;
    src.brownout = stage2_lvl;
    any_src      = |src;
  end

  // chip reset asserts combinationally from any source, releases on the clock
  assign chip_rst = any_src | (state_q inside {RBS_HOLD, RBS_WAIT_OSC, RBS_COUNT,
                                                RBS_FLASH});
  assign core_run        = (state_q == RBS_RUN) & ~any_src;
  assign reset_out_pin_n = out_n_q;
  assign flash_access_ok = flash_ok_q;
  assign brownout_irq    = stage1_lvl;
  assign brownout_status = stage1_lvl;
  assign fetch_addr      = BOOT_ADDR;

  // ----------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    from_brownout_d = from_brownout_q;
    out_n_d    = out_n_q;
    flash_ok_d = flash_ok_q;
    ds_d       = ds_q;
    if (any_src) begin
      state_d    = RBS_HOLD;
      cnt_d      = '0;
      out_n_d    = 1'b0;
      flash_ok_d = 1'b0;
      if (src.brownout) begin
        from_brownout_d = 1'b1;
      end
    end else begin
      case (state_q)
        RBS_HOLD: begin
          state_d = RBS_WAIT_OSC;      // pin now released
        end
        RBS_WAIT_OSC: begin
          cnt_d = '0;
          if (osc_running) begin
            state_d = RBS_COUNT;
          end
        end
        RBS_COUNT: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RST_FIXED_CYCLES - 1)) begin
            state_d = RBS_FLASH;
          end
        end
        RBS_FLASH: begin
          if (flash_init_done) begin
            state_d    = RBS_RUN;
            flash_ok_d = 1'b1;
          end
        end
        RBS_RUN: begin
          // brownout reset keeps the pin low until supply is back up
          if (!from_brownout_q || !stage1_lvl) begin
            out_n_d         = 1'b1;
            from_brownout_d = 1'b0;
          end
          if (pd_req || deep_sleep_req) begin
            state_d    = RBS_PD;
            ds_d       = deep_sleep_req & ~pd_req;
            flash_ok_d = ds_d;         // deep sleep keeps flash powered
          end
        end
        RBS_PD: begin
          cnt_d = '0;
          if (ext_irq && ext_irq_wake_en) begin
            state_d = RBS_WAKE;
          end
        end
        RBS_WAKE: begin
          // counter runs on: resume count by oscillator choice after deep sleep, flash timer after power-down
          cnt_d = cnt_q + 1'b1;
          if (ds_q) begin
            if (cnt_q == (main_osc_sel ? CNT_W'(RESUME_MAIN_CYCLES - 1)
                                       : CNT_W'(RESUME_RC_CYCLES - 1))) begin
              state_d = RBS_RUN;
            end
          end else if (cnt_q == CNT_W'(FLASH_WAKE_CYCLES - 1)) begin
            state_d    = RBS_RUN;
            flash_ok_d = 1'b1;
          end
        end
        default: begin
          state_d = RBS_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= RBS_HOLD;
      cnt_q      <= '0;
      from_brownout_q <= 1'b0;
      out_n_q    <= 1'b0;
      flash_ok_q <= 1'b0;
      ds_q       <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      from_brownout_q <= from_brownout_d;
      out_n_q    <= out_n_d;
      flash_ok_q <= flash_ok_d;
      ds_q       <= ds_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  src_forces_reset_a: assert property (@(posedge clk) disable iff (rst)
    any_src |-> (chip_rst && !core_run) ##1 (state_q == RBS_HOLD))
    else $error("source active without chip reset");
  src_drops_pin_a: assert property (@(posedge clk) disable iff (rst)
    any_src |=> !reset_out_pin_n) else $error("reset pin not low after source");
  // flash entry must follow exactly 64 count cycles that began after the oscillator wait
  count_before_flash_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RBS_FLASH && $past(state_q) == RBS_COUNT)
      |-> ($past(state_q, 64) == RBS_COUNT && $past(state_q, 65) == RBS_WAIT_OSC))
    else $error("fixed reset count wrong");
  osc_gate_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RBS_WAIT_OSC && !osc_running) |=> chip_rst)
    else $error("reset released without oscillator");
  brownout_pin_hold_a: assert property (@(posedge clk) disable iff (rst)
    (from_brownout_q && stage1_lvl) |=> !reset_out_pin_n)
    else $error("pin high while supply still low");
  irq_status_a: assert property (@(posedge clk) disable iff (rst)
    brownout_irq == brownout_status) else $error("status differs from interrupt");
  stage2_reset_a: assert property (@(posedge clk) disable iff (rst)
    $rose(stage2_lvl) |-> chip_rst ##1 (state_q == RBS_HOLD))
    else $error("brownout did not reset");
  hyst_filter_a: assert property (@(posedge clk) disable iff (rst)
    $rose(stage1_lvl) |-> $past(brownout_cmp.below_stage1, 8))
    else $error("stage one changed without steady input");
  wake_en_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RBS_PD && !(ext_irq && ext_irq_wake_en) && !any_src)
      |=> state_q == RBS_PD) else $error("woke without enabled interrupt");
  // four wake cycles on the rc clock, running on the fifth
  rc_resume_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RBS_WAKE && $past(state_q) == RBS_PD && ds_q && !main_osc_sel && !any_src)
      ##1 (!any_src && !main_osc_sel) [*3] |=> state_q == RBS_RUN)
    else $error("rc resume count wrong");
  flash_wake_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RBS_WAKE && !ds_q) |-> !flash_access_ok)
    else $error("flash usable before wake timer");
endmodule
`default_nettype wire

/* rbs_far_model.sv */
// far-side model: reset pin driver and flash controller init
`timescale 1ns/1ps
`default_nettype none
module rbs_far_model #(
  parameter int FLASH_DLY = 3
) (
  // clock and control from the bench
  input  wire logic clk,
  input  wire logic pin_hold,
  input  wire logic chip_rst,
  // far-side levels
  output logic      ext_rst_n,
  output logic      flash_init_done
);
  logic [3:0] cnt_q  = 4'h0;
  logic       prev_q = 1'b0;
  // flash init restarts on every new chip reset, done a few clocks later
  always_ff @(posedge clk) begin
    prev_q <= chip_rst;
    if (chip_rst && !prev_q) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'(FLASH_DLY)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign flash_init_done = (cnt_q == 4'(FLASH_DLY));
  assign ext_rst_n       = !pin_hold;  // pin is driven, never floats
endmodule
`default_nettype wire

/* tb_rbs_seq.sv */
// self-checking bench for the reset and brownout sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_rbs_seq;
  import rbs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, pin_hold = 1'b0, wdt = 1'b0, por = 1'b0;
  logic osc = 1'b0, msel = 1'b0, pd = 1'b0, ds = 1'b0, irq = 1'b0, wen = 1'b0;
  rbs_cmp_type cmp = '0;
  logic ext_n, fdone, pin_n, crst, birq, bstat, crun, fok;
  logic [31:0] faddr;
  int fails = 0, n_tests = 0, n, ticks = 0;

  always #25 clk = ~clk;

  rbs_far_model rbs_far_model_inst (.clk(clk), .pin_hold(pin_hold), .chip_rst(crst),
    .ext_rst_n(ext_n), .flash_init_done(fdone));
  rbs_seq rbs_seq_inst (.clk(clk), .rst(rst), .ext_rst_n(ext_n), .wdt_rst(wdt),
    .por_rst(por), .brownout_cmp(cmp), .osc_running(osc), .flash_init_done(fdone),
    .main_osc_sel(msel), .pd_req(pd), .deep_sleep_req(ds), .ext_irq(irq),
    .ext_irq_wake_en(wen), .reset_out_pin_n(pin_n), .chip_rst(crst),
    .brownout_irq(birq), .brownout_status(bstat), .fetch_addr(faddr), .core_run(crun),
    .flash_access_ok(fok));

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp=%0h seen=%0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // bounded wait: 0 chip reset gone, 1 core running, 2 flash usable
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (n < lim && !((sel == 0) ? crst === 1'b0 :
                        (sel == 1) ? crun === 1'b1 : fok === 1'b1)) begin
      @(negedge clk);
      n++;
    end
  endtask
  function automatic logic inb(input int lo, input int hi);
    return n >= lo && n <= hi;
  endfunction

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_on();
    cyc(3);
    rst = 1'b0;
    cyc(100);
    check("held_no_osc", crst, 1'b1);
    check("pin_low", pin_n, 1'b0);
    osc = 1'b1;
    wait_for(0, 200);
    check("count_len", inb(64, 68), 1'b1);
    cyc(2);
    check("pin_high", pin_n, 1'b1);
    check("fetch", faddr, BOOT_ADDR);
    check("run", crun, 1'b1);
  endtask
  // pin, watchdog and power-on sources in turn
  task automatic t_source(input int sel);
    pin_hold = (sel == 0);
    wdt = (sel == 1);
    por = (sel == 2);
    #1 check("rst_at_once", crst, 1'b1);
    cyc(2);
    check("pin_low_src", pin_n, 1'b0);
    check("run_off", crun, 1'b0);
    {pin_hold, wdt, por} = 3'h0;
    wait_for(0, 200);
    check("rerun_len", inb(64, 70), 1'b1);
    cyc(2);
    check("pin_back", pin_n, 1'b1);
  endtask
  task automatic t_brownout();
    cmp.below_stage1 = 1'b1;  // short glitch must be filtered
    cyc(4);
    cmp.below_stage1 = 1'b0;
    cyc(10);
    check("glitch", birq, 1'b0);
    cmp = 2'h3;
    cyc(14);
    check("irq", birq, 1'b1);
    check("status", bstat, 1'b1);
    check("brownout_rst", crst, 1'b1);
    cyc(50);
    check("brownout_hold", crst, 1'b1);
    cmp.below_stage2 = 1'b0;
    wait_for(0, 300);
    check("brownout_rel", crst, 1'b0);
    check("brownout_len", inb(72, 78), 1'b1);
    cyc(3);
    check("pin_waits", pin_n, 1'b0);
    cmp.below_stage1 = 1'b0;
    cyc(14);
    check("pin_up", pin_n, 1'b1);
    check("irq_off", birq, 1'b0);
  endtask
  task automatic t_power_down();
    pd = 1'b1;
    cyc(1);
    pd = 1'b0;
    cyc(2);
    check("pd_flash", fok, 1'b0);
    irq = 1'b1;  // wake not enabled yet: refused
    cyc(20);
    check("no_wake", crun, 1'b0);
    wen = 1'b1;
    wait_for(2, 2500);
    check("flash_wait", inb(1995, 2010), 1'b1);
    {irq, wen} = 2'h0;
    cyc(2);
  endtask
  task automatic t_deep(input logic main);
    msel = main;
    ds = 1'b1;
    cyc(1);
    ds = 1'b0;
    cyc(2);
    check("ds_stop", crun, 1'b0);
    {irq, wen} = 2'h3;
    wait_for(1, 5000);
    check("resume", main ? inb(4090, 4105) : inb(1, 10), 1'b1);
    check("ds_flash", fok, 1'b1);
    {irq, wen, msel} = 3'h0;
    cyc(2);
  endtask

  // ----------------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the roughly 6700 cycles the scenarios need
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    t_power_on();
    for (int s = 0; s < 3; s++) t_source(s);
    t_brownout();
    t_power_down();
    t_deep(1'b0);
    t_deep(1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
